// File: include/wiper_consts.svh
// Purpose: constants for the dual wiper two-wire write decoder
// Assumes: included by bare name
// Notes:   all positions and codes are 8 bits
`ifndef WIPER_CONSTS_SVH
`define WIPER_CONSTS_SVH
// arbitrary value for the fixed upper address bits
`define ADDR_FIXED_HI    4'h6
`define CMD_LOAD_FIRST   8'h11
`define CMD_LOAD_SECOND  8'h12
`define CMD_LOAD_BOTH    8'h13
`define WIPER_RESET      8'h80
`define WIPER_LOW_END    8'h00
`define WIPER_HIGH_END   8'hff
`define BITS_PER_BYTE    4'h8
`define ACK_SLOT         4'h9
`endif

// File: include/wiper_pkg.sv
// Purpose: types shared by the decoder files
// Assumes: nothing
// Notes:   line samples travel as one struct
package wiper_pkg;
  typedef struct packed {
    logic scl;
    logic sda;
  } line_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD  = 3'b011,
    ST_DATA = 3'b010,
    ST_SKIP = 3'b110
  } phase_t;
endpackage

// File: rtl/line_events.sv
// Purpose: start, stop and clock edge detection on the serial lines
// Assumes: lines already synchronous to clock_i
// Notes:   one cycle pulses
`timescale 1ns/10ps
module line_events (
  // clock and reset
  input  wire logic           clock_i,
  input  wire logic           rst_i,
  // lines
  input  wire wiper_pkg::line_t line_i,
  // events
  output logic                start_o,
  output logic                stop_o,
  output logic                rise_o,
  output logic                fall_o
);
  import wiper_pkg::*;
  line_t prev_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prev_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      prev_reg <= line_i;
    end
  end

  assign start_o = prev_reg.scl & line_i.scl & prev_reg.sda & ~line_i.sda;
  assign stop_o  = prev_reg.scl & line_i.scl & ~prev_reg.sda & line_i.sda;
  assign rise_o  = ~prev_reg.scl & line_i.scl;
  assign fall_o  = prev_reg.scl & ~line_i.scl;
endmodule

// File: rtl/wiper_decoder.sv
// Purpose: write-only two-wire slave loading two wiper positions
// Assumes: serial lines are synchronous inputs, master makes the clock
// Notes:   no readback; position registers drive the wiper taps directly
// How it works
// - first byte after the address is command, the next is data.
// - data goes to the position register chosen by the command.
// - command 11h loads the first wiper position.
// - command 12h loads the second wiper position.
// - command 13h loads both wiper positions with the same data.
// - code 00h is the low terminal end and ffh the high terminal end.
// - both positions reset to midscale 80h.
// - address low three bits match the straps, upper four are fixed.
// - a high eighth address bit makes the transfer a no-operation.
// - the slave pulls data low on the ninth clock of each taken byte.
// - a loaded position shows on the wiper output at once.
`timescale 1ns/10ps
`include "wiper_consts.svh"
module wiper_decoder #(
  parameter int POS_W = 8
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // straps
  input  wire logic             addr_strap_bit2_i,
  input  wire logic             addr_strap_bit1_i,
  input  wire logic             addr_strap_bit0_i,
  // serial lines
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o,
  // wiper taps
  output logic [POS_W-1:0]      wiper_a_position_o,
  output logic [POS_W-1:0]      wiper_b_position_o
);
  import wiper_pkg::*;

  line_t            line;
  logic             start_ev;
  logic             stop_ev;
  logic             rise_ev;
  logic             fall_ev;
  phase_t           phase_reg;
  logic [3:0]       bit_cnt_reg;
  logic [7:0]       shift_reg;
  logic [7:0]       cmd_reg;
  logic             ack_reg;
  logic [POS_W-1:0] wiper_a_position_reg;
  logic [POS_W-1:0] wiper_b_position_reg;
  logic [7:0]       byte_in;
  logic             byte_done;
  logic [6:0]       own_addr;

  assign line = '{scl: scl_i, sda: sda_i};

  line_events u_events (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .line_i  (line),
    .start_o (start_ev),
    .stop_o  (stop_ev),
    .rise_o  (rise_ev),
    .fall_o  (fall_ev)
  );

  function automatic logic cmd_hits_a(input logic [7:0] c);
    return (c == `CMD_LOAD_FIRST) || (c == `CMD_LOAD_BOTH);
  endfunction

  function automatic logic cmd_hits_b(input logic [7:0] c);
    return (c == `CMD_LOAD_SECOND) || (c == `CMD_LOAD_BOTH);
  endfunction

  assign own_addr = {`ADDR_FIXED_HI, addr_strap_bit2_i,
                     addr_strap_bit1_i, addr_strap_bit0_i};
  assign byte_in   = {shift_reg[6:0], sda_i};
  assign byte_done = rise_ev && (bit_cnt_reg == 4'h7);

  // bit counter: bits sampled so far, 8 waits for the fall, 9 is ack slot
  // ack waits for scl low so sda never moves while scl is high
  always_ff @(posedge clock_i) begin
    if (rst_i || start_ev || stop_ev) begin
      bit_cnt_reg <= 4'h0;
    end else if (rise_ev && bit_cnt_reg < `BITS_PER_BYTE) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end else if (fall_ev && bit_cnt_reg == `BITS_PER_BYTE) begin
      bit_cnt_reg <= `ACK_SLOT;
    end else if (fall_ev && bit_cnt_reg == `ACK_SLOT) begin
      bit_cnt_reg <= 4'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      shift_reg <= 8'h00;
    end else if (rise_ev && bit_cnt_reg < `BITS_PER_BYTE) begin
      shift_reg <= byte_in;
    end
  end

  // phase sequence address, command, data
  always_ff @(posedge clock_i) begin
    if (rst_i || stop_ev) begin
      phase_reg <= ST_IDLE;
    end else if (start_ev) begin
      phase_reg <= ST_ADDR;
    end else if (byte_done) begin
      unique case (phase_reg)
        ST_ADDR: begin
          // write bit low and own address only; else ignore the bytes that follow
          if (byte_in[7:1] == own_addr && !byte_in[0]) begin
            phase_reg <= ST_CMD;
          end else begin
            phase_reg <= ST_SKIP;
          end
        end
        ST_CMD:  phase_reg <= ST_DATA;
        ST_DATA: phase_reg <= ST_CMD;
        ST_IDLE: phase_reg <= ST_IDLE;
        ST_SKIP: phase_reg <= ST_SKIP;
        default: phase_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cmd_reg <= 8'h00;
    end else if (byte_done && phase_reg == ST_CMD) begin
      cmd_reg <= byte_in;
    end
  end

  // ack: a nop address is still acknowledged, a foreign one is not
  always_ff @(posedge clock_i) begin
    if (rst_i || start_ev || stop_ev) begin
      ack_reg <= 1'b0;
    end else if (byte_done) begin
      ack_reg <= (phase_reg == ST_ADDR) ? (byte_in[7:1] == own_addr)
               : (phase_reg == ST_CMD || phase_reg == ST_DATA);
    end else if (fall_ev && bit_cnt_reg == `ACK_SLOT) begin
      ack_reg <= 1'b0;
    end
  end

  // drive low only after the eighth bit's falling edge
  assign sda_o    = 1'b0;
  assign sda_oe_o = ack_reg && (bit_cnt_reg == `ACK_SLOT);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wiper_a_position_reg <= POS_W'(`WIPER_RESET);
    end else if (byte_done && phase_reg == ST_DATA
                 && cmd_hits_a(cmd_reg)) begin
      wiper_a_position_reg <= POS_W'(byte_in);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wiper_b_position_reg <= POS_W'(`WIPER_RESET);
    end else if (byte_done && phase_reg == ST_DATA
                 && cmd_hits_b(cmd_reg)) begin
      wiper_b_position_reg <= POS_W'(byte_in);
    end
  end

  // code is the tap index counted from the low terminal
  assign wiper_a_position_o = wiper_a_position_reg;
  assign wiper_b_position_o = wiper_b_position_reg;

  logic data_load_a;
  logic data_load_b;
  assign data_load_a = byte_done && phase_reg == ST_DATA
                       && cmd_hits_a(cmd_reg);
  assign data_load_b = byte_done && phase_reg == ST_DATA
                       && cmd_hits_b(cmd_reg);

  AST_RESET_MID: assert property (@(posedge clock_i)
    $fell(rst_i) |-> wiper_a_position_o == `WIPER_RESET
                     && wiper_b_position_o == `WIPER_RESET)
    else $error("positions not midscale after reset");

  AST_LOAD_A: assert property (@(posedge clock_i) disable iff (rst_i)
    data_load_a |=> wiper_a_position_o == $past(byte_in))
    else $error("first wiper not loaded");

  AST_LOAD_B: assert property (@(posedge clock_i) disable iff (rst_i)
    data_load_b |=> wiper_b_position_o == $past(byte_in))
    else $error("second wiper not loaded");

  AST_BOTH: assert property (@(posedge clock_i) disable iff (rst_i)
    (data_load_a && cmd_reg == `CMD_LOAD_BOTH) |=>
      wiper_a_position_o == wiper_b_position_o)
    else $error("both wipers differ after joint load");

  AST_HOLD_A: assert property (@(posedge clock_i) disable iff (rst_i)
    !data_load_a |=> $stable(wiper_a_position_o))
    else $error("first wiper changed without load");

  AST_HOLD_B: assert property (@(posedge clock_i) disable iff (rst_i)
    !data_load_b |=> $stable(wiper_b_position_o))
    else $error("second wiper changed without load");

  AST_ACK_SLOT: assert property (@(posedge clock_i) disable iff (rst_i)
    sda_oe_o |-> bit_cnt_reg == `ACK_SLOT && sda_o == 1'b0)
    else $error("ack driven outside ninth bit");

  AST_FOREIGN: assert property (@(posedge clock_i) disable iff (rst_i)
    (byte_done && phase_reg == ST_ADDR && byte_in[7:1] != own_addr)
      |=> phase_reg == ST_SKIP)
    else $error("foreign address accepted");

  AST_NOP: assert property (@(posedge clock_i) disable iff (rst_i)
    (byte_done && phase_reg == ST_ADDR && byte_in[0]) |=>
      phase_reg != ST_CMD)
    else $error("nop address entered command phase");

  AST_CMD_DATA: assert property (@(posedge clock_i) disable iff (rst_i)
    (byte_done && phase_reg == ST_CMD && !start_ev && !stop_ev)
      |=> phase_reg == ST_DATA)
    else $error("data phase not after command");

  COV_LOAD_A: cover property (@(posedge clock_i) data_load_a);
  COV_LOAD_B: cover property (@(posedge clock_i) data_load_b);
  COV_BOTH: cover property (@(posedge clock_i)
    data_load_a && data_load_b);
  COV_SKIP: cover property (@(posedge clock_i) phase_reg == ST_SKIP);
endmodule

// File: testbench/two_wire_host.sv
// Purpose: behavioural two-wire bus master for the wiper decoder
// Assumes: data line pulled up and resolved by the bench
// Notes:   lines move 1 ns after a rising edge, held >= 3 cycles
`timescale 1ns/10ps
module two_wire_host (
  // clock
  input  wire logic clock_i,
  // lines
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // one clock pulse, returns the level seen while scl is high
  task automatic put_bit(input logic b, output logic s);
    sda_o = b;
    hold(3);
    scl_o = 1'b1;
    hold(3);
    s = sda_i;
    hold(1);
    scl_o = 1'b0;
    hold(1);
  endtask
  // n bytes sent msb first, address byte first
  task automatic xfer(input logic [23:0] bytes, input int n,
                      output logic [2:0] nak);
    logic s;
    nak = 3'b000;
    sda_o = 1'b0;
    hold(4);
    scl_o = 1'b0;
    hold(2);
    for (int k = 0; k < n; k++) begin
      for (int i = 23 - 8 * k; i > 15 - 8 * k; i--) begin
        put_bit(bytes[i], s);
      end
      put_bit(1'b1, s); // released so the slave can answer
      nak[2-k] = s;
    end
    sda_o = 1'b0;
    hold(2);
    scl_o = 1'b1;
    hold(3);
    sda_o = 1'b1;
    hold(4);
  endtask
endmodule

// File: testbench/tb_dual_wiper_i2c_write_decoder.sv
// Purpose: self-checking bench for the wiper decoder
// Assumes: host model makes every transfer
// Notes:   nop transfers only judge the address acknowledge
`timescale 1ns/10ps
module tb_dual_wiper_i2c_write_decoder;
  typedef struct packed {
    logic [2:0] strap;
    logic [7:0] adr;
    logic [7:0] cmd;
    logic [7:0] dat;
    logic [7:0] ea;
    logic [7:0] eb;
    logic [2:0] enak;
  } row_t;
  logic       clock_i;
  logic       rst_i;
  logic [2:0] strap;
  logic       scl;
  logic       host_sda;
  logic       sda;
  logic       dut_sda;
  logic       dut_sda_oe;
  logic [7:0] pos_a;
  logic [7:0] pos_b;
  logic [2:0] nak;
  logic [2:0] m;
  int         error_cnt;
  int         checks;
  row_t       rows [7];
  // pull-up wins unless the host or the slave pulls low
  assign sda = host_sda & (dut_sda_oe ? dut_sda : 1'b1);
  two_wire_host MST (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
                     .sda_o(host_sda));
  wiper_decoder DUT (
    .clock_i(clock_i), .rst_i(rst_i),
    .addr_strap_bit2_i(strap[2]), .addr_strap_bit1_i(strap[1]),
    .addr_strap_bit0_i(strap[0]), .scl_i(scl), .sda_i(sda),
    .sda_o(dut_sda), .sda_oe_o(dut_sda_oe),
    .wiper_a_position_o(pos_a), .wiper_b_position_o(pos_b));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst_i = 1'b1;
    strap = 3'b101;
    error_cnt = 0;
    checks = 0;
    rows[0] = {3'b101, 8'h6a, 8'h11, 8'h00, 8'h00, 8'h80, 3'b000};
    rows[1] = {3'b101, 8'h6a, 8'h12, 8'hff, 8'h00, 8'hff, 3'b000};
    rows[2] = {3'b101, 8'h6a, 8'h13, 8'h3c, 8'h3c, 8'h3c, 3'b000};
    rows[3] = {3'b101, 8'h6b, 8'h11, 8'h55, 8'h3c, 8'h3c, 3'b000};
    rows[4] = {3'b101, 8'h68, 8'h13, 8'h55, 8'h3c, 8'h3c, 3'b111};
    rows[5] = {3'b101, 8'h6a, 8'h14, 8'h55, 8'h3c, 8'h3c, 3'b000};
    rows[6] = {3'b010, 8'h64, 8'h11, 8'ha5, 8'ha5, 8'h3c, 3'b000};
    repeat (5) @(posedge clock_i);
    #1 rst_i = 1'b0;
    @(posedge clock_i);
    #1;
    chk(pos_a, 8'h80);
    chk(pos_b, 8'h80);
    foreach (rows[r]) begin
      strap = rows[r].strap;
      MST.xfer({rows[r].adr, rows[r].cmd, rows[r].dat}, 3, nak);
      m = rows[r].adr[0] ? 3'b100 : 3'b111;
      chk(pos_a, rows[r].ea);
      chk(pos_b, rows[r].eb);
      chk({5'h0, nak & m}, {5'h0, rows[r].enak});
    end
    // lone command before stop loads nothing
    MST.xfer({8'h64, 8'h13, 8'h00}, 2, nak);
    chk(pos_a, 8'ha5);
    chk(pos_b, 8'h3c);
    rst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1 rst_i = 1'b0;
    chk(pos_a, 8'h80);
    chk(pos_b, 8'h80);
    @(posedge clock_i);
    #1;
    MST.xfer({8'h64, 8'h12, 8'h07}, 3, nak);
    chk(pos_a, 8'h80);
    chk(pos_b, 8'h07);
    report_and_stop();
  end
endmodule
